/* hw/pmrc_top.v */
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "pmrc_defines.vh"
module pmrc_top #(
  parameter [2:0] BO_VSEL_OPT = 3'h0,
  parameter PIN_RESET_OPT = 1
) (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire irq_any,
  input wire irq_deep_wake,
  input wire wdt_run_in_deep,
  input wire lpt_run_in_deep,
  input wire reset_pin_n,
  input wire brownout_det,
  input wire port_lowvolt_det,
  input wire watchdog_reset,
  input wire stack_overflow_reset,
  input wire debug_entry_req,
  output reg cpu_clk_en,
  output reg periph_clk_en,
  output reg wdt_clk_en,
  output reg lpt_clk_en,
  output reg fast_osc_run,
  output reg core_reset,
  output reg ram_invalid,
  output reg pin_is_gpio,
  output reg debug_entry_ok,
  output reg [2:0] bo_threshold
);
  reg [7:0] power_control_reg;
  reg [7:0] reset_cause_reg;
  reg [7:0] pin_reset_debounce;
  reg [7:0] brownout_debounce;
  reg [7:0] bo_ctl_r;
  reg [7:0] pl_ctl_r;
  reg [7:0] prog_command_high;
  reg [7:0] prog_command_low;
  reg [7:0] clock_switch_reg;
  reg [7:0] cpu_clock_divider;
  reg [1:0] por_sync_r;
  reg soft_req_r;
  reg [1:0] soft_hold_r;
  reg irq_s1_r, irq_s2_r, dw_s1_r, dw_s2_r;
  reg pin_s1_r, pin_s2_r, bo_s1_r, bo_s2_r;
  reg pl_s1_r, pl_s2_r, wd_s1_r, wd_s2_r, sp_s1_r, sp_s2_r;
  wire pin_q, bo_q, pl_q;
  wire deep_now, light_now, pin_active, any_src;
  wire [7:0] new_causes;
  wire wr_acc, rd_acc;
  reg [31:0] rdata_nxt;
  reg addr_ok;

  // Two-flop synchronisers for all outside requests except debug_entry_req
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
      dw_s1_r <= 1'b0;
      dw_s2_r <= 1'b0;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      bo_s1_r <= 1'b0;
      bo_s2_r <= 1'b0;
      pl_s1_r <= 1'b0;
      pl_s2_r <= 1'b0;
      wd_s1_r <= 1'b0;
      wd_s2_r <= 1'b0;
      sp_s1_r <= 1'b0;
      sp_s2_r <= 1'b0;
    end else begin
      irq_s1_r <= irq_any;
      irq_s2_r <= irq_s1_r;
      dw_s1_r <= irq_deep_wake;
      dw_s2_r <= dw_s1_r;
      pin_s1_r <= ~reset_pin_n & (PIN_RESET_OPT != 0);
      pin_s2_r <= pin_s1_r;
      bo_s1_r <= brownout_det & bo_ctl_r[`PMRC_BO_EN];
      bo_s2_r <= bo_s1_r;
      pl_s1_r <= port_lowvolt_det & pl_ctl_r[`PMRC_PL_EN];
      pl_s2_r <= pl_s1_r;
      wd_s1_r <= watchdog_reset;
      wd_s2_r <= wd_s1_r;
      sp_s1_r <= stack_overflow_reset;
      sp_s2_r <= sp_s1_r;
    end
  end

  assign deep_now = power_control_reg[`PMRC_PC_DEEP];
  assign light_now = power_control_reg[`PMRC_PC_IDLE] & ~deep_now;

  // Debouncers, bypassed while in deep sleep
  pmrc_debounce #(.CW(11)) u_pin_dbc (
    .clk(clk),
    .sys_rst(sys_rst),
    .level_in(pin_s2_r),
    .enable(~deep_now),
    .setting(pin_reset_debounce),
    .qualified(pin_q)
  );
  pmrc_debounce #(.CW(11)) u_bo_dbc (
    .clk(clk),
    .sys_rst(sys_rst),
    .level_in(bo_s2_r),
    .enable(bo_ctl_r[`PMRC_BO_DBEN] & ~deep_now),
    .setting(brownout_debounce),
    .qualified(bo_q)
  );
  pmrc_debounce #(.CW(11)) u_pl_dbc (
    .clk(clk),
    .sys_rst(sys_rst),
    .level_in(pl_s2_r),
    .enable(pl_ctl_r[`PMRC_PL_DBEN] & ~deep_now),
    .setting(brownout_debounce),
    .qualified(pl_q)
  );

  // Raw pin level gates debug entry, no debounce wait
  assign pin_active = pin_s2_r;
  assign any_src = pin_q | bo_q | pl_q | wd_s2_r | sp_s2_r | soft_req_r;
  assign new_causes = {1'b0, pin_q, bo_q, wd_s2_r, soft_req_r, 1'b0,
    sp_s2_r, pl_q};

  // APB: zero wait states, error on unmapped address
  assign wr_acc = psel & penable & pwrite & addr_ok;
  assign rd_acc = psel & ~pwrite;

  always @* begin
    addr_ok = 1'b1;
    rdata_nxt = 32'h00000000;
    if (paddr == `PMRC_OFF_PCTRL) begin
      rdata_nxt[7:0] = power_control_reg;
    end else if (paddr == `PMRC_OFF_CAUSE) begin
      rdata_nxt[7:0] = reset_cause_reg;
    end else if (paddr == `PMRC_OFF_PINDBC) begin
      rdata_nxt[7:0] = pin_reset_debounce;
    end else if (paddr == `PMRC_OFF_BODBC) begin
      rdata_nxt[7:0] = brownout_debounce;
    end else if (paddr == `PMRC_OFF_BOCTL) begin
      rdata_nxt[7:0] = bo_ctl_r;
    end else if (paddr == `PMRC_OFF_PLCTL) begin
      rdata_nxt[7:0] = pl_ctl_r;
    end else if (paddr == `PMRC_OFF_PCMDH) begin
      rdata_nxt[7:0] = prog_command_high;
    end else if (paddr == `PMRC_OFF_PCMDL) begin
      rdata_nxt[7:0] = prog_command_low;
    end else if (paddr == `PMRC_OFF_CLKSW) begin
      rdata_nxt[7:0] = clock_switch_reg;
    end else if (paddr == `PMRC_OFF_CPUDIV) begin
      rdata_nxt[7:0] = cpu_clock_divider;
    end else begin
      addr_ok = 1'b0;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= (psel & ~penable & rd_acc) ? rdata_nxt : 32'h00000000;
    end
  end

  // Power-on marker: first clocked edges after release
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_sync_r <= 2'b00;
    end else begin
      por_sync_r <= {por_sync_r[0], 1'b1};
    end
  end

  // Registers and power-mode sequencing
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_control_reg <= 8'h00;
      reset_cause_reg <= 8'h80;
      pin_reset_debounce <= `PMRC_PINDBC_RST;
      brownout_debounce <= `PMRC_BODBC_RST;
      bo_ctl_r <= `PMRC_BOCTL_RST;
      pl_ctl_r <= `PMRC_PLCTL_RST;
      prog_command_high <= 8'h00;
      prog_command_low <= 8'h00;
      clock_switch_reg <= 8'h00;
      cpu_clock_divider <= `PMRC_CPUDIV_RST;
      soft_req_r <= 1'b0;
      soft_hold_r <= 2'b00;
      bo_threshold <= 3'h0;
    end else begin
      if (por_sync_r == 2'b01) begin
        bo_threshold <= BO_VSEL_OPT;
        bo_ctl_r[`PMRC_BO_VSEL_W-1:0] <= BO_VSEL_OPT;
      end
      if (wr_acc) begin
        if (paddr == `PMRC_OFF_PCTRL) begin
          power_control_reg <= pwdata[7:0] & `PMRC_PC_WMASK;
        end else if (paddr == `PMRC_OFF_CAUSE) begin
          reset_cause_reg <= pwdata[7:0] & `PMRC_RC_MASK;
        end else if (paddr == `PMRC_OFF_PINDBC) begin
          pin_reset_debounce <= pwdata[7:0];
        end else if (paddr == `PMRC_OFF_BODBC) begin
          brownout_debounce <= pwdata[7:0];
        end else if (paddr == `PMRC_OFF_BOCTL) begin
          bo_ctl_r <= pwdata[7:0] & 8'hC7;
          bo_threshold <= pwdata[`PMRC_BO_VSEL_W-1:0];
        end else if (paddr == `PMRC_OFF_PLCTL) begin
          pl_ctl_r <= pwdata[7:0] & 8'h03;
        end else if (paddr == `PMRC_OFF_PCMDH) begin
          prog_command_high <= pwdata[7:0];
        end else if (paddr == `PMRC_OFF_PCMDL) begin
          prog_command_low <= pwdata[7:0];
          if (prog_command_high == `PMRC_KEY_HI &&
              pwdata[7:0] == `PMRC_KEY_LO) begin
            soft_req_r <= 1'b1;
          end
        end else if (paddr == `PMRC_OFF_CLKSW) begin
          clock_switch_reg <= pwdata[7:0];
        end else if (paddr == `PMRC_OFF_CPUDIV) begin
          cpu_clock_divider <= pwdata[7:0];
        end
      end
      // Software reset pulse held three cycles
      if (soft_req_r) begin
        soft_hold_r <= {soft_hold_r[0], 1'b1};
        if (soft_hold_r[1]) begin
          soft_req_r <= 1'b0;
          soft_hold_r <= 2'b00;
        end
        prog_command_high <= 8'h00;
        prog_command_low <= 8'h00;
        clock_switch_reg[`PMRC_CS_FOSC_LO+1:`PMRC_CS_FOSC_LO] <=
          `PMRC_FOSC_SW;
        cpu_clock_divider <= `PMRC_CPUDIV_SW;
      end
      // Wake-up clears request bits (both when deep)
      if (deep_now && (dw_s2_r || any_src)) begin
        power_control_reg[1:0] <= 2'b00;
      end else if (light_now && (irq_s2_r || any_src)) begin
        power_control_reg[`PMRC_PC_IDLE] <= 1'b0;
      end
      // Reset causes: set wins over a software clear
      reset_cause_reg <= (wr_acc && paddr == `PMRC_OFF_CAUSE ?
        pwdata[7:0] & `PMRC_RC_MASK : reset_cause_reg) | new_causes;
    end
  end

  // Clock gates and core reset
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      wdt_clk_en <= 1'b0;
      lpt_clk_en <= 1'b0;
      fast_osc_run <= 1'b1;
      core_reset <= 1'b1;
      ram_invalid <= 1'b1;
      pin_is_gpio <= 1'b0;
      debug_entry_ok <= 1'b0;
    end else begin
      cpu_clk_en <= ~deep_now & ~light_now;
      periph_clk_en <= ~deep_now;
      wdt_clk_en <= ~deep_now | wdt_run_in_deep;
      lpt_clk_en <= ~deep_now | lpt_run_in_deep;
      fast_osc_run <= ~deep_now;
      core_reset <= any_src | ~por_sync_r[1];
      if (por_sync_r[1]) begin
        ram_invalid <= 1'b0;
      end
      pin_is_gpio <= (PIN_RESET_OPT == 0);
      debug_entry_ok <= debug_entry_req & ~pin_active;
    end
  end
endmodule

/* hw/pmrc_defines.vh */
`ifndef PMRC_DEFINES_VH
`define PMRC_DEFINES_VH
// Register byte offsets
`define PMRC_OFF_PCTRL 12'h000
`define PMRC_OFF_CAUSE 12'h004
`define PMRC_OFF_PINDBC 12'h008
`define PMRC_OFF_BODBC 12'h00C
`define PMRC_OFF_BOCTL 12'h010
`define PMRC_OFF_PLCTL 12'h014
`define PMRC_OFF_PCMDH 12'h018
`define PMRC_OFF_PCMDL 12'h01C
`define PMRC_OFF_CLKSW 12'h020
`define PMRC_OFF_CPUDIV 12'h024
// Power control fields
`define PMRC_PC_IDLE 0
`define PMRC_PC_DEEP 1
`define PMRC_PC_WMASK 8'h0F
// Reset cause bit positions
`define PMRC_RC_POR 7
`define PMRC_RC_PIN 6
`define PMRC_RC_BO 5
`define PMRC_RC_WDT 4
`define PMRC_RC_SW 3
`define PMRC_RC_SPOV 1
`define PMRC_RC_PLV 0
`define PMRC_RC_MASK 8'hFB
// Reset values
`define PMRC_PINDBC_RST 8'hFF
`define PMRC_BODBC_RST 8'h00
`define PMRC_BOCTL_RST 8'h80
`define PMRC_PLCTL_RST 8'h01
`define PMRC_CPUDIV_RST 8'h02
`define PMRC_CPUDIV_SW 8'h08
`define PMRC_FOSC_SW 2'h1
// Control bit positions
`define PMRC_BO_EN 7
`define PMRC_BO_DBEN 6
`define PMRC_BO_VSEL_W 3
`define PMRC_PL_EN 0
`define PMRC_PL_DBEN 1
`define PMRC_CS_FOSC_LO 4
// Software reset key sequence
`define PMRC_KEY_HI 8'h5A
`define PMRC_KEY_LO 8'hA5
// Debounce: value * 8 + 2 cycles
`define PMRC_DBC_SHIFT 3
`define PMRC_DBC_ADD 11'h002
`endif

/* hw/pmrc_debounce.v */
`timescale 1ns/10ps
`include "pmrc_defines.vh"
module pmrc_debounce #(
  parameter CW = 11
) (
  input wire clk,
  input wire sys_rst,
  input wire level_in,
  input wire enable,
  input wire [7:0] setting,
  output reg qualified
);
  reg [CW-1:0] cnt_r;
  wire [CW-1:0] limit;
  assign limit = {{(CW-11){1'b0}}, {setting, 3'b000} + `PMRC_DBC_ADD};
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= {CW{1'b0}};
      qualified <= 1'b0;
    end else if (!level_in) begin
      cnt_r <= {CW{1'b0}};
      qualified <= 1'b0;
    end else if (!enable) begin
      qualified <= 1'b1;
    end else if (cnt_r >= limit) begin
      qualified <= 1'b1;
    end else begin
      cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule

/* verification/pmrc_src_model.sv */
`timescale 1ns/10ps
module pmrc_src_model (
  input wire clk,
  input wire sys_rst,
  input wire cpu_clk_en,
  input wire pin_press,
  input wire irq_fire,
  input wire irq_deep_sel,
  output wire reset_pin_n,
  output wire irq_any,
  output wire irq_deep_wake
);
  reg pend_r;
  // Pull-up holds the pin high unless pressed
  assign reset_pin_n = ~pin_press;
  assign irq_any = pend_r;
  assign irq_deep_wake = pend_r & irq_deep_sel;
  // Request stays pending until the core runs to take it
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      pend_r <= 1'b0;
    else if (irq_fire)
      pend_r <= 1'b1;
    else if (cpu_clk_en)
      pend_r <= 1'b0;
  end
endmodule

/* verification/pmrc_chk.sv */
`timescale 1ns/10ps
module pmrc_chk (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire irq_any,
  input wire irq_deep_wake,
  input wire stack_overflow_reset,
  input wire reset_pin_n,
  input wire debug_entry_ok,
  input wire cpu_clk_en,
  input wire periph_clk_en,
  input wire core_reset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence pc_write_s;
    psel && penable && pready && pwrite && paddr == 12'h000;
  endsequence
  bus_answer_a: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  light_enter_a: assert property (pc_write_s ##0 pwdata[1:0] == 2'h1 |->
    ##[1:3] (!cpu_clk_en && periph_clk_en)) else $error("light entry");
  deep_enter_a: assert property (pc_write_s ##0 pwdata[1] |->
    ##[1:3] (!cpu_clk_en && !periph_clk_en)) else $error("deep entry");
  light_wake_a: assert property (!cpu_clk_en && periph_clk_en && irq_any
    && !core_reset |-> ##[1:6] cpu_clk_en) else $error("light wake");
  deep_wake_a: assert property (!periph_clk_en && irq_deep_wake
    && !core_reset |-> ##[1:6] cpu_clk_en) else $error("deep wake");
  reset_hold_a: assert property (stack_overflow_reset [*5] |-> core_reset)
    else $error("reset not held");
  pin_debug_a: assert property (!reset_pin_n [*4] |-> !debug_entry_ok)
    else $error("debug entry allowed");
  reserved_zero_a: assert property (pready && !pwrite && paddr == 12'h000
    |-> prdata[31:4] == 28'h0) else $error("reserved bits set");
endmodule
bind pmrc_top pmrc_chk pmrc_chk_i (.*);

/* verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  reg clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  reg pwrite = 1'b0, wdt_run_in_deep = 1'b1, lpt_run_in_deep = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rdat;
  reg brownout_det = 1'b0, port_lowvolt_det = 1'b0, err;
  reg watchdog_reset = 1'b0, stack_overflow_reset = 1'b0;
  reg debug_entry_req = 1'b0, pin_press = 1'b0;
  reg irq_fire = 1'b0, irq_deep_sel = 1'b0;
  wire [31:0] prdata;
  wire [2:0] bo_threshold;
  wire pready, pslverr, irq_any, irq_deep_wake, reset_pin_n;
  wire cpu_clk_en, periph_clk_en, wdt_clk_en, lpt_clk_en, fast_osc_run;
  wire core_reset, ram_invalid, pin_is_gpio, debug_entry_ok;
  integer bad_count = 0, n_compared = 0;
  always #50 clk = ~clk;
  pmrc_top pmrc_top_i (.*);
  pmrc_src_model pmrc_src_model_i (.*);
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task hang;
    $display("ERROR wait expired");
    bad_count = bad_count + 1;
    summarize;
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      $display("ERROR %0s expected %h seen %h", nm, exp, got);
      bad_count = bad_count + 1;
    end
  endtask
  task apb(input w, input [11:0] a, input [7:0] d);
    integer n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) hang;
  endtask
  task rd(input [11:0] a, input [31:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, rdat, e);
  endtask
  task fire;
    irq_fire <= 1'b1;
    @(posedge clk);
    irq_fire <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task wait_low;
    integer n;
    for (n = 0; core_reset !== 1'b0; n = n + 1) begin
      if (n > 300) hang;
      @(posedge clk);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(12'h000, 32'h00, "pctrl");
    rd(12'h004, 32'h80, "cause");
    rd(12'h008, 32'hFF, "pin dbc");
    chk("bo thr", {29'h0, bo_threshold}, 32'h0);
    apb(1'b0, 12'h040, 8'h00);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, 12'h010, 8'h85);
    repeat (2) @(posedge clk);
    chk("bo thr", {29'h0, bo_threshold}, 32'h5);
    apb(1'b1, 12'h000, 8'hFC);
    rd(12'h000, 32'h0C, "pctrl rsv");
    $display("registers done");
    apb(1'b1, 12'h000, 8'h05);
    repeat (3) @(posedge clk);
    chk("light cpu", {31'h0, cpu_clk_en}, 32'h0);
    chk("light per", {31'h0, periph_clk_en}, 32'h1);
    fire;
    rd(12'h000, 32'h04, "light clr");
    apb(1'b1, 12'h000, 8'h07);
    repeat (3) @(posedge clk);
    chk("deep per", {31'h0, periph_clk_en}, 32'h0);
    chk("deep wdt", {31'h0, wdt_clk_en}, 32'h1);
    chk("deep lpt", {31'h0, lpt_clk_en}, 32'h0);
    chk("deep osc", {31'h0, fast_osc_run}, 32'h0);
    chk("pin func", {31'h0, pin_is_gpio}, 32'h0);
    fire;
    chk("deep hold", {31'h0, cpu_clk_en}, 32'h0);
    irq_deep_sel <= 1'b1;
    repeat (8) @(posedge clk);
    rd(12'h000, 32'h04, "deep clr");
    $display("sleep done");
    apb(1'b1, 12'h008, 8'h02);
    pin_press <= 1'b1;
    debug_entry_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk("pin short", {31'h0, core_reset}, 32'h0);
    repeat (30) @(posedge clk);
    chk("pin rst", {31'h0, core_reset}, 32'h1);
    chk("dbg block", {31'h0, debug_entry_ok}, 32'h0);
    pin_press <= 1'b0;
    wait_low;
    repeat (3) @(posedge clk);
    chk("ram kept", {31'h0, ram_invalid}, 32'h0);
    chk("dbg ok", {31'h0, debug_entry_ok}, 32'h1);
    rd(12'h004, 32'hC0, "pin flag");
    apb(1'b1, 12'h004, 8'h00);
    rd(12'h004, 32'h00, "cause clr");
    watchdog_reset <= 1'b1;
    stack_overflow_reset <= 1'b1;
    repeat (10) @(posedge clk);
    watchdog_reset <= 1'b0;
    repeat (10) @(posedge clk);
    chk("multi hold", {31'h0, core_reset}, 32'h1);
    stack_overflow_reset <= 1'b0;
    wait_low;
    rd(12'h004, 32'h12, "multi flag");
    apb(1'b1, 12'h004, 8'h00);
    brownout_det <= 1'b1;
    repeat (5) @(posedge clk);
    brownout_det <= 1'b0;
    wait_low;
    rd(12'h004, 32'h20, "bo flag");
    apb(1'b1, 12'h004, 8'h00);
    port_lowvolt_det <= 1'b1;
    repeat (5) @(posedge clk);
    port_lowvolt_det <= 1'b0;
    wait_low;
    rd(12'h004, 32'h01, "plv flag");
    apb(1'b1, 12'h004, 8'h00);
    $display("resets done");
    apb(1'b1, 12'h020, 8'h03);
    apb(1'b1, 12'h018, 8'h5A);
    apb(1'b1, 12'h01C, 8'hA5);
    repeat (4) @(posedge clk);
    wait_low;
    rd(12'h004, 32'h08, "sw flag");
    apb(1'b0, 12'h020, 8'h00);
    chk("fosc div", rdat & 32'h30, 32'h10);
    chk("clk sel kept", rdat & 32'h0F, 32'h03);
    rd(12'h024, 32'h08, "cpu div");
    $display("soft reset done");
    summarize;
  end
endmodule
